/* rtl/seq_prog_consts.svh */
// Opcodes, status bit positions and timing for the sequential program block
//
// Function
// - Frame opens with AD/AF opcode, MSB first
// - First frame sends 24-bit address, bit 23 first
// - First frame then carries one data byte
// - First frame end programs byte at given address
// - Later frames: opcode then data, no address
// - Later frames program at internal address counter
// - Write enable latch stays set between frames, except after programming the top address
// - Busy flag set during self-timed byte program
// - While busy, only a small subset accepted
// - Mode accepts sequential, write enable, write disable
// - Mode accepts status reads, interrupt, terminate
// - Mode accepts reset pair and identification reads
// - Mode rejects reads, erases, other programs, suspend
// - Mode rejects status writes, locks, power commands
// - Busy flag is bit 0 of status
// - Partial byte at frame end aborts, clears latch
// - Clearing write enable latch leaves the mode
`ifndef SEQ_PROG_CONSTS_SVH
`define SEQ_PROG_CONSTS_SVH

// Opcodes
`define OP_NONE 8'h00
`define OP_SEQ_A 8'had
`define OP_SEQ_B 8'haf
`define OP_WREN 8'h06
`define OP_WRDI 8'h04
`define OP_RDSR1 8'h05
`define OP_RDSR2 8'h35
`define OP_RDSR3 8'h15
`define OP_RDSR_IND 8'h65
`define OP_ASI 8'h25
`define OP_TERM 8'hf0
`define OP_RSTEN 8'h66
`define OP_RST 8'h99
`define OP_ID_A 8'h9f
`define OP_ID_B 8'h90
`define OP_ID_C 8'h94

// Status register layout
`define SR_BUSY_BIT 0
`define SR_WEL_BIT 1
`define SR_RESET 8'h00

// Address handling
`define ADDR_BYTES_LAST 2'h2
`define ADDR_LAST 24'hffffff
`define ADDR_ONE 24'h000001
`define BIT_LAST 3'h7

// Timing: self-timed byte program
`define SYS_CLK_HZ 20000000
`define BYTE_PROGRAM_TIME_NS 20000
`define BP_CYCLES ((`BYTE_PROGRAM_TIME_NS * (`SYS_CLK_HZ / 1000000) + 999) / 1000)
`define BP_CNT_W 16

`endif

/* rtl/seq_prog_pkg.sv */
// Types shared by the sequential program block
package seq_prog_pkg;
    // Where the current frame stands
    typedef enum logic [1:0] {
        ph_opcode,
        ph_addr,
        ph_data,
        ph_ignore
    } frame_phase_type;
endpackage

/* rtl/bit_sync.sv */
// Two-flop synchroniser for three link-side levels
module bit_sync (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [2:0] async_in,
    output logic [2:0] sync_out
);
    ////////////////////////////////////////////////////////////////////
    logic [2:0] stage1; // Read by stage two only
    logic [2:0] next_stage1;
    logic [2:0] next_sync_out;

    // Shift chain
    always_comb begin
        next_stage1 = async_in;
        next_sync_out = stage1;
    end

    // Registers; reset to the idle levels {mid_byte 0, toggle 0, cs_n 1}
    // so no false edge is seen once reset lets go
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stage1 <= 3'h1;
            sync_out <= 3'h1;
        end else begin
            stage1 <= next_stage1;
            sync_out <= next_sync_out;
        end
    end
endmodule // bit_sync

/* rtl/spi_frame_rx.sv */
// Link-side byte assembler running on the serial clock
`include "seq_prog_consts.svh"
module spi_frame_rx (
    input wire logic spi_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic mosi,
    output logic [7:0] rx_byte,
    output logic rx_toggle,
    output logic mid_byte
);
    ////////////////////////////////////////////////////////////////////
    logic frame_rst; // Clears the bit position between frames
    logic [2:0] bit_cnt; // Bits of the current byte seen
    logic [7:0] shift; // Incoming bits, MSB first
    logic [2:0] next_bit_cnt;
    logic [7:0] next_shift;
    logic [7:0] next_rx_byte;
    logic next_rx_toggle;
    logic next_mid_byte;
    logic byte_done;

    assign frame_rst = rst | cs_n;

    // Shift on the rising serial edge, MSB first
    always_comb begin
        next_bit_cnt = bit_cnt + 3'h1;
        next_shift = {shift[6:0], mosi};
        byte_done = (bit_cnt == `BIT_LAST);
        next_rx_byte = byte_done ? next_shift : rx_byte;
        next_rx_toggle = rx_toggle ^ byte_done; // Event crosses as a toggle
        // Kept past frame end: the clock stops, so this level is stable for the sync
        next_mid_byte = (next_bit_cnt != 3'h0);
    end

    // Bit position, reset whenever chip select is high
    always_ff @(posedge spi_clk or posedge frame_rst) begin
        if (frame_rst) begin
            bit_cnt <= 3'h0;
            shift <= 8'h00;
        end else begin
            bit_cnt <= next_bit_cnt;
            shift <= next_shift;
        end
    end

    // Handed-over byte; held for a whole byte time, long after the toggle syncs
    always_ff @(posedge spi_clk or posedge rst) begin
        if (rst) begin
            rx_byte <= 8'h00;
            rx_toggle <= 1'b0;
            mid_byte <= 1'b0;
        end else begin
            rx_byte <= next_rx_byte;
            rx_toggle <= next_rx_toggle;
            mid_byte <= next_mid_byte;
        end
    end
endmodule // spi_frame_rx

/* rtl/sequential_byte_program_mode.sv */
// Command interpreter for sequential byte program mode
`include "seq_prog_consts.svh"
module sequential_byte_program_mode (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic spi_clk,
    input wire logic cs_n,
    input wire logic mosi,
    output logic prog_start,
    output logic [23:0] prog_addr,
    output logic [7:0] prog_data,
    output logic busy_flag,
    output logic write_enable_latch,
    output logic sequential_program_flag,
    output logic [7:0] first_status_register,
    output logic cmd_rejected
);
    import seq_prog_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Link side and crossing
    logic [7:0] rx_byte; // Stable while its toggle is synchronised
    logic rx_toggle;
    logic mid_byte;
    logic [2:0] synced; // {mid_byte, toggle, cs_n}
    logic cs_prev; // Last synced chip select
    logic tog_prev; // Last synced toggle
    logic byte_ev; // One byte arrived
    logic frame_end; // Chip select went high
    logic frame_begin; // Chip select went low
    logic mid_byte_s; // Synced partial-byte level

    spi_frame_rx u_rx (
        .spi_clk(spi_clk),
        .rst(rst),
        .cs_n(cs_n),
        .mosi(mosi),
        .rx_byte(rx_byte),
        .rx_toggle(rx_toggle),
        .mid_byte(mid_byte)
    );

    bit_sync u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in({mid_byte, rx_toggle, cs_n}),
        .sync_out(synced)
    );

    // Edges of the synchronised levels
    always_comb begin
        byte_ev = synced[1] ^ tog_prev;
        frame_end = synced[0] & ~cs_prev;
        frame_begin = ~synced[0] & cs_prev;
        mid_byte_s = synced[2]; // Settles before the chip select rise arrives
    end

    ////////////////////////////////////////////////////////////////////
    // Command classes
    function automatic logic is_seq(input logic [7:0] op);
        is_seq = (op == `OP_SEQ_A) || (op == `OP_SEQ_B);
    endfunction

    // Accepted while the program timer runs; everything else is ignored
    function automatic logic busy_ok(input logic [7:0] op);
        case (op)
            `OP_RDSR1, `OP_RDSR2, `OP_RDSR3, `OP_RDSR_IND: busy_ok = 1'b1;
            `OP_ASI, `OP_TERM, `OP_RSTEN, `OP_RST: busy_ok = 1'b1;
            default: busy_ok = 1'b0;
        endcase
    endfunction

    // Accepted in the mode when idle
    function automatic logic mode_ok(input logic [7:0] op);
        case (op)
            `OP_SEQ_A, `OP_SEQ_B, `OP_WREN, `OP_WRDI: mode_ok = 1'b1;
            `OP_RDSR1, `OP_RDSR2, `OP_RDSR3, `OP_RDSR_IND: mode_ok = 1'b1;
            `OP_ASI, `OP_TERM: mode_ok = 1'b1;
            `OP_RSTEN, `OP_RST, `OP_ID_A, `OP_ID_B, `OP_ID_C: mode_ok = 1'b1;
            default: mode_ok = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Interpreter state
    frame_phase_type phase, next_phase;
    logic [7:0] cmd, next_cmd; // Opcode of this frame
    logic [1:0] addr_idx, next_addr_idx; // Address bytes seen
    logic [23:0] addr_shift, next_addr_shift; // Start address of first frame
    logic [23:0] addr_cnt, next_addr_cnt; // Internal address counter
    logic [7:0] data_reg, next_data_reg; // Last data byte of the frame
    logic have_data, next_have_data;
    logic reset_armed, next_reset_armed; // Reset enable seen in last frame
    logic [`BP_CNT_W-1:0] timer, next_timer; // Byte program countdown
    logic next_prog_start;
    logic [23:0] next_prog_addr;
    logic [7:0] next_prog_data;
    logic next_busy;
    logic next_wel;
    logic next_mode;
    logic [7:0] next_status;
    logic next_rejected;
    logic allowed;
    logic [23:0] target;

    // Next-state logic: byte events first, then the frame end on the same cycle
    always_comb begin
        next_phase = phase;
        next_cmd = cmd;
        next_addr_idx = addr_idx;
        next_addr_shift = addr_shift;
        next_addr_cnt = addr_cnt;
        next_data_reg = data_reg;
        next_have_data = have_data;
        next_reset_armed = reset_armed;
        next_timer = timer;
        next_prog_start = 1'b0;
        next_prog_addr = prog_addr;
        next_prog_data = prog_data;
        next_wel = write_enable_latch;
        next_mode = sequential_program_flag;
        next_rejected = 1'b0;
        allowed = 1'b1;
        target = sequential_program_flag ? addr_cnt : addr_shift;

        // Self-timed program runs down
        if (timer != '0) begin
            next_timer = timer - 1'b1;
        end

        // New frame starts at the opcode
        if (frame_begin) begin
            next_phase = ph_opcode;
            next_cmd = `OP_NONE;
            next_have_data = 1'b0;
            next_addr_idx = 2'h0;
        end

        if (byte_ev) begin
            case (phase)
                ph_opcode: begin
                    allowed = busy_flag ? busy_ok(rx_byte)
                            : (sequential_program_flag ? mode_ok(rx_byte) : 1'b1);
                    next_phase = ph_ignore;
                    if (!allowed) begin
                        // Dropped with no side effect on mode, latch or counter
                        next_cmd = `OP_NONE;
                        next_rejected = 1'b1;
                    end else begin
                        next_cmd = rx_byte;
                        if (is_seq(rx_byte) && !busy_flag) begin
                            if (sequential_program_flag) begin
                                next_phase = ph_data;
                            end else if (write_enable_latch) begin
                                next_phase = ph_addr;
                            end
                        end
                    end
                end
                ph_addr: begin
                    next_addr_shift = {addr_shift[15:0], rx_byte};
                    next_addr_idx = addr_idx + 2'h1;
                    if (addr_idx == `ADDR_BYTES_LAST) begin
                        next_phase = ph_data;
                    end
                end
                ph_data: begin
                    // Extra bytes overwrite; only the last one is programmed
                    next_data_reg = rx_byte;
                    next_have_data = 1'b1;
                end
                default: begin
                    // Trailing bytes of other commands are ignored
                end
            endcase
        end

        if (frame_end) begin
            next_phase = ph_ignore;
            if (phase == ph_addr || (phase == ph_data && (!next_have_data || mid_byte_s))) begin
                // Partial address or data: nothing programmed, latch dropped
                next_wel = 1'b0;
            end else if (phase == ph_data) begin
                next_prog_addr = target;
                next_prog_data = next_data_reg;
                next_prog_start = 1'b1;
                next_timer = `BP_CNT_W'(`BP_CYCLES);
                next_mode = 1'b1;
                next_addr_cnt = target + `ADDR_ONE;
                if (target == `ADDR_LAST) begin
                    // No wrap past the top of the array
                    next_wel = 1'b0;
                end
            end else if (!mid_byte_s) begin
                next_reset_armed = (cmd == `OP_RSTEN);
                case (cmd)
                    `OP_WREN: next_wel = 1'b1;
                    `OP_WRDI: next_wel = 1'b0;
                    `OP_TERM: begin
                        // Cut the running program short
                        next_timer = '0;
                        next_wel = 1'b0;
                    end
                    `OP_RST: begin
                        if (reset_armed) begin
                            next_timer = '0;
                            next_wel = 1'b0;
                        end
                    end
                    default: begin
                        // Reads and notices have no effect here
                    end
                endcase
            end
        end

        // The mode lives only as long as the latch
        if (!next_wel) begin
            next_mode = 1'b0;
        end

        next_busy = (next_timer != '0);
        next_status = `SR_RESET;
        next_status[`SR_BUSY_BIT] = next_busy;
        next_status[`SR_WEL_BIT] = next_wel;
    end

    // State registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cs_prev <= 1'b1;
            tog_prev <= 1'b0;
            phase <= ph_ignore;
            cmd <= `OP_NONE;
            addr_idx <= 2'h0;
            addr_shift <= '0;
            addr_cnt <= '0;
            data_reg <= 8'h00;
            have_data <= 1'b0;
            reset_armed <= 1'b0;
            timer <= '0;
            prog_start <= 1'b0;
            prog_addr <= '0;
            prog_data <= 8'h00;
            busy_flag <= 1'b0;
            write_enable_latch <= 1'b0;
            sequential_program_flag <= 1'b0;
            first_status_register <= `SR_RESET;
            cmd_rejected <= 1'b0;
        end else begin
            cs_prev <= synced[0];
            tog_prev <= synced[1];
            phase <= next_phase;
            cmd <= next_cmd;
            addr_idx <= next_addr_idx;
            addr_shift <= next_addr_shift;
            addr_cnt <= next_addr_cnt;
            data_reg <= next_data_reg;
            have_data <= next_have_data;
            reset_armed <= next_reset_armed;
            timer <= next_timer;
            prog_start <= next_prog_start;
            prog_addr <= next_prog_addr;
            prog_data <= next_prog_data;
            busy_flag <= next_busy;
            write_enable_latch <= next_wel;
            sequential_program_flag <= next_mode;
            first_status_register <= next_status;
            cmd_rejected <= next_rejected;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    localparam int BP_LIM = `BP_CYCLES;

    sequence s_opcode_idle;
        byte_ev && phase == ph_opcode && !busy_flag;
    endsequence

    sequence s_first_entry;
        s_opcode_idle ##0 is_seq(rx_byte) && !sequential_program_flag && write_enable_latch;
    endsequence

    sequence s_next_entry;
        s_opcode_idle ##0 is_seq(rx_byte) && sequential_program_flag;
    endsequence

    a_first_frame_addr: assert property (
        @(posedge sys_clk) disable iff (rst) s_first_entry |=> phase == ph_addr)
        else $error("first frame did not expect an address");

    a_next_frame_data: assert property (
        @(posedge sys_clk) disable iff (rst) s_next_entry |=> phase == ph_data)
        else $error("later frame did not go straight to data");

    a_busy_on_start: assert property (
        @(posedge sys_clk) disable iff (rst) prog_start |-> busy_flag [*8])
        else $error("busy flag not held after program start");

    a_busy_ends: assert property (
        @(posedge sys_clk) disable iff (rst)
        prog_start && !frame_end |-> ##[1:BP_LIM] !busy_flag)
        else $error("byte program never finished");

    a_status_busy_bit: assert property (
        @(posedge sys_clk) disable iff (rst)
        first_status_register[`SR_BUSY_BIT] == busy_flag)
        else $error("status bit 0 differs from busy");

    a_counter_step: assert property (
        @(posedge sys_clk) disable iff (rst) prog_start |-> addr_cnt == prog_addr + `ADDR_ONE)
        else $error("address counter did not advance");

    a_wel_kept: assert property (
        @(posedge sys_clk) disable iff (rst)
        prog_start && prog_addr != `ADDR_LAST |-> write_enable_latch && sequential_program_flag)
        else $error("latch or mode lost after program start");

    a_mode_needs_wel: assert property (
        @(posedge sys_clk) disable iff (rst) sequential_program_flag |-> write_enable_latch)
        else $error("mode active without latch");

    a_partial_abort: assert property (
        @(posedge sys_clk) disable iff (rst)
        frame_end && mid_byte_s && phase == ph_data |=> !prog_start && !write_enable_latch)
        else $error("partial byte was not aborted");

    a_busy_reject: assert property (
        @(posedge sys_clk) disable iff (rst)
        byte_ev && phase == ph_opcode && busy_flag && rx_byte == `OP_WREN |=> cmd_rejected)
        else $error("write enable accepted while busy");

    a_reject_holds: assert property (
        @(posedge sys_clk) disable iff (rst)
        cmd_rejected |-> $stable(write_enable_latch) && $stable(addr_cnt))
        else $error("rejected command changed state");
endmodule // sequential_byte_program_mode

/* sim/spi_host_model.sv */
// Behavioural SPI host that frames opcode, address and data bytes for the flash block
module spi_host_model (
    output logic spi_clk,
    output logic cs_n,
    output logic mosi
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////////
    // Idle state: clock parked low, chip select released
    initial begin
        spi_clk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One frame of n bits taken from the low end of the stream, top bit first
    // Link clock has a 160 ns period and runs only inside the frame
    task automatic frame(input logic [39:0] stream, input int n);
        int i;
        #37;
        cs_n = 1'b0; // Odd offset keeps the link phase unrelated to sys_clk
        for (i = n - 1; i >= 0; i--) begin
            mosi = stream[i]; // Opcode, then address high byte first, then data
            #80;
            spi_clk = 1'b1;
            #80;
            spi_clk = 1'b0;
        end
        #80;
        cs_n = 1'b1;
        mosi = ~mosi; // Released line no longer shows the last bit
    endtask
endmodule // spi_host_model

/* sim/test_sequential_byte_program_mode.sv */
// Self-checking bench for the sequential byte program command block
module test_sequential_byte_program_mode;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk; // 20 MHz system clock
    logic rst; // Asynchronous reset, active high
    logic spi_clk; // Link clock from the host model
    logic cs_n; // Chip select, active low
    logic mosi; // Serial data to the block
    logic prog_start;
    logic [23:0] prog_addr;
    logic [7:0] prog_data;
    logic busy_flag;
    logic write_enable_latch;
    logic sequential_program_flag;
    logic [7:0] first_status_register;
    logic cmd_rejected;
    int error_cnt = 0; // Mismatches seen
    int checks_done = 0; // Comparisons made
    int rej_cnt = 0; // Refusal pulses seen
    int start_cnt = 0; // Program start pulses seen
    int r;
    int s;
    // Opcodes the mode must refuse, and opcodes it must take
    logic [7:0] bad_ops [17] = '{8'h03, 8'h02, 8'h75, 8'h01, 8'h36, 8'hb9, 8'hd4, 8'h60,
        8'h84, 8'h0a, 8'hb0, 8'hd0, 8'h50, 8'h4b, 8'h5a, 8'h77, 8'hef};
    logic [7:0] good_ops [9] = '{8'h05, 8'h35, 8'h15, 8'h65, 8'h25, 8'h9f, 8'h90, 8'h94, 8'h06};

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and instances
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    spi_host_model u_spi_host_model (.spi_clk(spi_clk), .cs_n(cs_n), .mosi(mosi));

    sequential_byte_program_mode u_sequential_byte_program_mode (
        .sys_clk(sys_clk), .rst(rst), .spi_clk(spi_clk), .cs_n(cs_n), .mosi(mosi),
        .prog_start(prog_start), .prog_addr(prog_addr), .prog_data(prog_data),
        .busy_flag(busy_flag), .write_enable_latch(write_enable_latch),
        .sequential_program_flag(sequential_program_flag),
        .first_status_register(first_status_register), .cmd_rejected(cmd_rejected));

    // One-cycle pulses are counted mid-cycle, where they stand settled
    always @(negedge sys_clk) begin
        if (prog_start === 1'b1) start_cnt++;
        if (cmd_rejected === 1'b1) rej_cnt++;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Tasks
    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic end_sim;
        $display("mismatches %0d comparisons %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Frame plus a gap well above the 4 cycle minimum, so frame-end effects have landed
    task automatic xfer(input logic [39:0] stream, input int n);
        u_spi_host_model.frame(stream, n);
        repeat (8) @(negedge sys_clk);
    endtask

    // Poll the busy flag rather than wait a fixed time, under a bound
    task automatic wait_idle;
        int i;
        for (i = 0; i < 600 && busy_flag !== 1'b0; i++) @(negedge sys_clk);
        chk("busy_flag idle", 24'h0, {23'h0, busy_flag});
        if (busy_flag !== 1'b0) begin
            end_sim();
        end
    endtask

    // A program frame must give one start with the expected place and byte
    task automatic prog(input logic [39:0] stream, input int n, input logic [23:0] a,
            input logic [7:0] d);
        int k;
        k = start_cnt;
        xfer(stream, n);
        chk("start count", 24'(k + 1), 24'(start_cnt));
        chk("prog_addr", a, prog_addr);
        chk("prog_data", {16'h0, d}, {16'h0, prog_data});
        chk("busy_flag", 24'h1, {23'h0, busy_flag});
        chk("status", 24'h3, {16'h0, first_status_register});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst = 1'b1;
        repeat (4) @(negedge sys_clk);
        rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk("status after reset", 24'h0, {16'h0, first_status_register});
        chk("mode after reset", 24'h0, {23'h0, sequential_program_flag});
        xfer({32'h0, 8'h06}, 8); // Latch set before the first frame
        chk("latch", 24'h1, {23'h0, write_enable_latch});
        prog({8'had, 24'h000102, 8'h5a}, 40, 24'h000102, 8'h5a);
        // While busy an identification read is refused, a status read is not
        r = rej_cnt;
        xfer({32'h0, 8'h9f}, 8);
        chk("refused while busy", 24'(r + 1), 24'(rej_cnt));
        xfer({32'h0, 8'h06}, 8);
        chk("write enable while busy", 24'(r + 2), 24'(rej_cnt));
        xfer({32'h0, 8'h05}, 8);
        chk("status read while busy", 24'(r + 2), 24'(rej_cnt));
        wait_idle();
        chk("status idle", 24'h2, {16'h0, first_status_register});
        chk("mode", 24'h1, {23'h0, sequential_program_flag});
        foreach (bad_ops[i]) begin
            r = rej_cnt;
            xfer({32'h0, bad_ops[i]}, 8);
            chk("refusal", 24'(r + 1), 24'(rej_cnt));
            chk("mode kept", 24'h1, {23'h0, sequential_program_flag});
            chk("latch kept", 24'h1, {23'h0, write_enable_latch});
        end
        r = rej_cnt;
        foreach (good_ops[i]) xfer({32'h0, good_ops[i]}, 8);
        chk("accepted set", 24'(r), 24'(rej_cnt));
        chk("mode after accepted", 24'h1, {23'h0, sequential_program_flag});
        // Counter continues from the last place, whichever opcode is used
        prog({24'h0, 8'had, 8'h77}, 16, 24'h000103, 8'h77);
        wait_idle();
        prog({24'h0, 8'haf, 8'h3c}, 16, 24'h000104, 8'h3c);
        wait_idle();
        // Five data bits only: nothing programmed, latch and mode dropped
        s = start_cnt;
        xfer({27'h0, 8'had, 5'h15}, 13);
        chk("start on partial byte", 24'(s), 24'(start_cnt));
        chk("latch after abort", 24'h0, {23'h0, write_enable_latch});
        chk("mode after abort", 24'h0, {23'h0, sequential_program_flag});
        // Re-enter with the other opcode, then end the mode with write disable
        xfer({32'h0, 8'h06}, 8);
        prog({8'haf, 24'h000010, 8'ha5}, 40, 24'h000010, 8'ha5);
        wait_idle();
        xfer({32'h0, 8'h04}, 8);
        chk("latch after disable", 24'h0, {23'h0, write_enable_latch});
        chk("mode after disable", 24'h0, {23'h0, sequential_program_flag});
        // Terminate, and the reset pair, both drop the latch
        xfer({32'h0, 8'h06}, 8);
        xfer({32'h0, 8'hf0}, 8);
        chk("latch after terminate", 24'h0, {23'h0, write_enable_latch});
        xfer({32'h0, 8'h06}, 8);
        xfer({32'h0, 8'h66}, 8);
        xfer({32'h0, 8'h99}, 8);
        chk("latch after reset pair", 24'h0, {23'h0, write_enable_latch});
        end_sim();
    end

    // Watchdog: a hang counts as a mismatch and goes to the closing report
    initial begin
        #2000000;
        error_cnt++;
        $display("unexpected run length: expected end seen timeout");
        end_sim();
    end
endmodule // test_sequential_byte_program_mode
